// File: rtl/aqc_pkg.sv
// Purpose: Shared constants and types for the four-input converter serial control.
// Assumes: One core clock; the serial pins are asynchronous to it.
// Notes:   Cycle numbers count serial clock periods from the start of a conversion.
// What this block does
// - First conversion after power-up runs at once, on input one.
// - Result is unsigned straight binary, 256 steps of supply over 256.
// - Track the selected input during the first three serial cycles.
// - Hold and convert from serial cycle four through sixteen.
// - Address shifted in now selects the channel of the next conversion.
// - Channel address is control word bits 5..3, bit 7 arrives first.
// - Control word bits 7..6 and 2..0 never affect operation.
// - Top address bit ignored; low two bits pick input one to four.
// - Result leaves on data out MSB first from the fifth cycle.
// - Data in sampled on the first eight rising edges of each conversion.
// - Data out floats while select is high, driven only while low.
// - After each sixteenth rising edge, next falling edge restarts tracking.
package aqc_pkg;
  // Widths
  localparam int unsigned CODE_W     = 8;
  localparam int unsigned CODE_STEPS = 256;
  localparam int unsigned CHAN_W     = 2;
  localparam int unsigned CYC_W      = 5;
  localparam int unsigned BUF_DEPTH  = 2;

  // Serial cycle landmarks within one conversion
  localparam logic [4:0] CYC_NONE       = 5'h00;
  localparam logic [4:0] CYC_FIRST      = 5'h01;
  localparam logic [4:0] CYC_LAST_TRACK = 5'h03;
  localparam logic [4:0] CYC_HOLD       = 5'h04;
  localparam logic [4:0] CYC_MSB        = 5'h05;
  localparam logic [4:0] CYC_LSB        = 5'h0C;
  localparam logic [4:0] CYC_LAST       = 5'h10;
  localparam logic [4:0] RISE_CTRL_LAST = 5'h07;

  // Reset values
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Conversion phase
  typedef enum logic [1:0] {
    AQC_IDLE  = 2'b00,
    AQC_TRACK = 2'b01,
    AQC_HOLD  = 2'b10
  } aqc_mode_t;

  // Control word as shifted in, bit 7 first
  typedef struct packed {
    logic [1:0] ignored_bit_hi;
    logic       chan_addr_bit_high;
    logic       chan_addr_bit_mid;
    logic       chan_addr_bit_low;
    logic [2:0] ignored_bit_lo;
  } aqc_ctrl_word_t;

  // One finished conversion
  typedef struct packed {
    logic [1:0] chan;
    logic [7:0] code;
  } aqc_result_t;

  localparam int unsigned RES_W = $bits(aqc_result_t);
endpackage

// File: rtl/aqc_pair_buf.sv
// Purpose: Small valid/ready buffer for finished conversion results.
// Assumes: Both sides on core_clk; ce freezes all state.
// Notes:   in_ready falls only when every entry is occupied.
module aqc_pair_buf #(
  parameter int unsigned WIDTH = aqc_pkg::RES_W,
  parameter int unsigned DEPTH = aqc_pkg::BUF_DEPTH
) (
  // Clock and control
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PTR_W-1:0] wr_reg;
  logic [PTR_W-1:0] wr_next;
  logic [PTR_W-1:0] rd_reg;
  logic [PTR_W-1:0] rd_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             push;
  logic             pop;

  // Honest flags straight from the occupancy count
  assign in_ready  = (cnt_reg != CNT_W'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];

  // Pointer and storage update
  always_comb begin
    push     = in_valid && in_ready && ce;
    pop      = out_valid && out_ready && ce;
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    if (push) begin
      mem_next[wr_reg] = in_data;
      wr_next = (wr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    cnt_next = cnt_reg + CNT_W'(push) - CNT_W'(pop);
  end

  // Registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_reg <= '{default: '0};
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      mem_reg <= mem_next;
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

// File: rtl/aqc_serial_ctrl.sv
// Purpose: Serial framing, track/hold sequencing and result shifting of the converter.
// Assumes: Serial pins and input levels are asynchronous; serial clock well below core_clk/4.
// Notes:   Input levels arrive already quantised to straight-binary codes.
module aqc_serial_ctrl (
  // Clock and control
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  // Serial pins
  input  wire logic                      cs_n_pin,
  input  wire logic                      sclk_pin,
  input  wire logic                      din_pin,
  output logic                           dout,
  output logic                           dout_oe_n,
  // Quantised input levels
  input  wire logic [aqc_pkg::CODE_W-1:0] analog_input_one,
  input  wire logic [aqc_pkg::CODE_W-1:0] analog_input_two,
  input  wire logic [aqc_pkg::CODE_W-1:0] analog_input_three,
  input  wire logic [aqc_pkg::CODE_W-1:0] analog_input_four,
  // Front-end control
  output logic [aqc_pkg::CHAN_W-1:0]      mux_sel,
  output logic                           track_en,
  output logic                           hold_en,
  // Result stream
  output logic                           res_valid,
  input  wire logic                      res_ready,
  output aqc_pkg::aqc_result_t           res_data,
  output logic                           res_lost
);
  // Synchroniser stages: [0] first flop, [1] second flop
  logic [1:0] cs_sync_reg;
  logic [1:0] cs_sync_next;
  logic [1:0] sclk_sync_reg;
  logic [1:0] sclk_sync_next;
  logic [1:0] din_sync_reg;
  logic [1:0] din_sync_next;
  logic       cs_d_reg;
  logic       cs_d_next;
  logic       sclk_d_reg;
  logic       sclk_d_next;
  logic [3:0][aqc_pkg::CODE_W-1:0] lvl_raw;
  logic [3:0][aqc_pkg::CODE_W-1:0] lvl_s1_reg;
  logic [3:0][aqc_pkg::CODE_W-1:0] lvl_s2_reg;

  // Conversion state
  aqc_pkg::aqc_mode_t                mode_reg;
  aqc_pkg::aqc_mode_t                mode_next;
  logic [aqc_pkg::CYC_W-1:0]         cyc_reg;
  logic [aqc_pkg::CYC_W-1:0]         cyc_next;
  logic [aqc_pkg::CYC_W-1:0]         rise_reg;
  logic [aqc_pkg::CYC_W-1:0]         rise_next;
  logic [aqc_pkg::CODE_W-1:0]        ctrl_sh_reg;
  logic [aqc_pkg::CODE_W-1:0]        ctrl_sh_next;
  logic [aqc_pkg::CHAN_W-1:0]        chan_reg;
  logic [aqc_pkg::CHAN_W-1:0]        chan_next;
  logic [aqc_pkg::CHAN_W-1:0]        active_reg;
  logic [aqc_pkg::CHAN_W-1:0]        active_next;
  logic [aqc_pkg::CODE_W-1:0]        sample_reg;
  logic [aqc_pkg::CODE_W-1:0]        sample_next;
  logic [aqc_pkg::CODE_W-1:0]        out_sh_reg;
  logic [aqc_pkg::CODE_W-1:0]        out_sh_next;
  logic                              dout_reg;
  logic                              dout_next;
  logic                              lost_reg;
  logic                              lost_next;

  // Decoded events
  logic                              cs_high;
  logic                              cs_fall;
  logic                              sclk_rise;
  logic                              sclk_fall;
  logic                              start_conv;
  logic                              push_res;
  logic                              buf_in_ready;
  aqc_pkg::aqc_ctrl_word_t           ctrl_word;
  aqc_pkg::aqc_result_t              push_data;

  assign lvl_raw = {analog_input_four, analog_input_three, analog_input_two, analog_input_one};

  // Pin synchronisers; only the second stage feeds logic
  always_comb begin
    cs_sync_next   = {cs_sync_reg[0], cs_n_pin};
    sclk_sync_next = {sclk_sync_reg[0], sclk_pin};
    din_sync_next  = {din_sync_reg[0], din_pin};
    cs_d_next      = cs_sync_reg[1];
    sclk_d_next    = sclk_sync_reg[1];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_sync_reg   <= 2'h3;
      sclk_sync_reg <= 2'h0;
      din_sync_reg  <= 2'h0;
      cs_d_reg      <= 1'b1;
      sclk_d_reg    <= 1'b0;
    end else if (ce) begin
      cs_sync_reg   <= cs_sync_next;
      sclk_sync_reg <= sclk_sync_next;
      din_sync_reg  <= din_sync_next;
      cs_d_reg      <= cs_d_next;
      sclk_d_reg    <= sclk_d_next;
    end
  end

  // Level synchronisers per input; levels must be steady around the hold edge
  for (genvar ch = 0; ch < 4; ch++) begin : g_lvl
    always_ff @(posedge core_clk) begin
      if (rst) begin
        lvl_s1_reg[ch] <= aqc_pkg::CODE_RESET;
        lvl_s2_reg[ch] <= aqc_pkg::CODE_RESET;
      end else if (ce) begin
        lvl_s1_reg[ch] <= lvl_raw[ch];
        lvl_s2_reg[ch] <= lvl_s1_reg[ch];
      end
    end
  end

  // Edge decode on synchronised pins
  assign cs_high   = cs_sync_reg[1];
  assign cs_fall   = cs_d_reg && !cs_sync_reg[1];
  assign sclk_rise = sclk_sync_reg[1] && !sclk_d_reg;
  assign sclk_fall = !sclk_sync_reg[1] && sclk_d_reg;
  assign ctrl_word = aqc_pkg::aqc_ctrl_word_t'({ctrl_sh_reg[6:0], din_sync_reg[1]});

  // Select low with clock low counts as the first falling edge
  always_comb begin
    start_conv = 1'b0;
    if (!cs_high) begin
      if (cs_fall) begin
        start_conv = !sclk_sync_reg[1];
      end else if (sclk_fall) begin
        start_conv = (cyc_reg == aqc_pkg::CYC_NONE) || (cyc_reg == aqc_pkg::CYC_LAST);
      end
    end
  end

  // Sequencer next state
  always_comb begin
    mode_next    = mode_reg;
    cyc_next     = cyc_reg;
    rise_next    = rise_reg;
    ctrl_sh_next = ctrl_sh_reg;
    chan_next    = chan_reg;
    active_next  = active_reg;
    sample_next  = sample_reg;
    out_sh_next  = out_sh_reg;
    dout_next    = dout_reg;
    push_res     = 1'b0;
    if (cs_high) begin
      mode_next = aqc_pkg::AQC_IDLE;
      cyc_next  = aqc_pkg::CYC_NONE;
      rise_next = aqc_pkg::CYC_NONE;
      dout_next = 1'b0;
    end else if (start_conv) begin
      mode_next   = aqc_pkg::AQC_TRACK;
      cyc_next    = aqc_pkg::CYC_FIRST;
      rise_next   = aqc_pkg::CYC_NONE;
      active_next = chan_reg;
      dout_next   = 1'b0;
    end else if (cs_fall) begin
      mode_next = aqc_pkg::AQC_IDLE;
      cyc_next  = aqc_pkg::CYC_NONE;
      rise_next = aqc_pkg::CYC_NONE;
    end else if (sclk_fall && cyc_reg != aqc_pkg::CYC_NONE) begin
      cyc_next = cyc_reg + 1'b1;
      if (cyc_next == aqc_pkg::CYC_HOLD) begin
        mode_next   = aqc_pkg::AQC_HOLD;
        sample_next = lvl_s2_reg[active_reg];
        out_sh_next = lvl_s2_reg[active_reg];
      end
      if (cyc_next >= aqc_pkg::CYC_MSB && cyc_next <= aqc_pkg::CYC_LSB) begin
        dout_next   = out_sh_reg[aqc_pkg::CODE_W-1];
        out_sh_next = {out_sh_reg[aqc_pkg::CODE_W-2:0], 1'b0};
      end else begin
        dout_next = 1'b0;
      end
      push_res = (cyc_next == aqc_pkg::CYC_MSB);
    end else if (sclk_rise && cyc_reg != aqc_pkg::CYC_NONE) begin
      rise_next = rise_reg + 1'b1;
      if (rise_reg <= aqc_pkg::RISE_CTRL_LAST) begin
        ctrl_sh_next = ctrl_word;
      end
      if (rise_reg == aqc_pkg::RISE_CTRL_LAST) begin
        // Only the low two address bits decode; the rest are dropped
        chan_next = {ctrl_word.chan_addr_bit_mid, ctrl_word.chan_addr_bit_low};
      end
    end
  end

  // Loss flag when the result buffer cannot accept
  always_comb begin
    lost_next = push_res && !buf_in_ready;
  end

  // Sequencer registers; power-up channel is input one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg    <= aqc_pkg::AQC_IDLE;
      cyc_reg     <= aqc_pkg::CYC_NONE;
      rise_reg    <= aqc_pkg::CYC_NONE;
      ctrl_sh_reg <= aqc_pkg::CTRL_RESET;
      chan_reg    <= aqc_pkg::CHAN_RESET;
      active_reg  <= aqc_pkg::CHAN_RESET;
      sample_reg  <= aqc_pkg::CODE_RESET;
      out_sh_reg  <= aqc_pkg::CODE_RESET;
      dout_reg    <= 1'b0;
      lost_reg    <= 1'b0;
    end else if (ce) begin
      mode_reg    <= mode_next;
      cyc_reg     <= cyc_next;
      rise_reg    <= rise_next;
      ctrl_sh_reg <= ctrl_sh_next;
      chan_reg    <= chan_next;
      active_reg  <= active_next;
      sample_reg  <= sample_next;
      out_sh_reg  <= out_sh_next;
      dout_reg    <= dout_next;
      lost_reg    <= lost_next;
    end
  end

  // Outputs
  assign dout      = dout_reg;
  assign dout_oe_n = cs_high;
  assign mux_sel   = active_reg;
  assign track_en  = (mode_reg == aqc_pkg::AQC_TRACK);
  assign hold_en   = (mode_reg == aqc_pkg::AQC_HOLD);
  assign res_lost  = lost_reg;
  assign push_data = '{chan: active_reg, code: sample_next};

  // Parallel result copy; a slow reader stalls only this path
  aqc_pair_buf #(
    .WIDTH (aqc_pkg::RES_W),
    .DEPTH (aqc_pkg::BUF_DEPTH)
  ) u_res_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (push_res),
    .in_ready  (buf_in_ready),
    .in_data   (push_data),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic first_seen_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      first_seen_reg <= 1'b0;
    end else if (ce && start_conv) begin
      first_seen_reg <= 1'b1;
    end
  end

  chk_first_chan_one: assert property (
    (ce && start_conv && !first_seen_reg) |=> (mux_sel == aqc_pkg::CHAN_RESET && track_en))
    else $error("first conversion not on input one");
  chk_result_code: assert property (
    (ce && push_res && buf_in_ready && !res_valid)
    |=> (res_valid && res_data.code == sample_reg && res_data.chan == mux_sel))
    else $error("queued result differs from held sample");
  chk_track_span: assert property (
    track_en |-> (cyc_reg >= aqc_pkg::CYC_FIRST && cyc_reg <= aqc_pkg::CYC_LAST_TRACK))
    else $error("tracking outside cycles one to three");
  chk_hold_span: assert property (
    hold_en |-> (cyc_reg >= aqc_pkg::CYC_HOLD && cyc_reg <= aqc_pkg::CYC_LAST))
    else $error("holding outside cycles four to sixteen");
  chk_hold_entry: assert property (
    (ce && sclk_fall && !cs_high && !cs_fall && cyc_reg == aqc_pkg::CYC_LAST_TRACK)
    |=> (hold_en && sample_reg == $past(lvl_s2_reg[active_reg])))
    else $error("hold not entered at fourth cycle");
  chk_next_chan: assert property (
    (ce && start_conv) |=> (mux_sel == $past(chan_reg)))
    else $error("conversion not on previously addressed channel");
  chk_addr_capture: assert property (
    (ce && sclk_rise && !cs_high && !cs_fall && !start_conv && cyc_reg != aqc_pkg::CYC_NONE
     && rise_reg == aqc_pkg::RISE_CTRL_LAST)
    |=> (chan_reg == $past({ctrl_sh_reg[3], ctrl_sh_reg[2]})))
    else $error("channel address not taken from bits four and three");
  chk_addr_stable: assert property (
    $changed(chan_reg) |-> $past(sclk_rise && rise_reg == aqc_pkg::RISE_CTRL_LAST))
    else $error("channel changed outside eighth rising edge");
  chk_msb_first: assert property (
    (ce && sclk_fall && !cs_high && !cs_fall && cyc_reg == aqc_pkg::CYC_HOLD)
    |=> (dout == sample_reg[aqc_pkg::CODE_W-1]))
    else $error("result MSB not on fifth cycle");
  chk_float_idle: assert property (
    cs_high |-> dout_oe_n)
    else $error("data out driven while select high");
  // Data register clears one cycle after select rises; the pin already floats
  chk_idle_zero: assert property (
    (cs_high && $past(cs_high)) |-> !dout)
    else $error("data out not cleared while select high");
  chk_retrack: assert property (
    (ce && sclk_fall && !cs_high && !cs_fall && cyc_reg == aqc_pkg::CYC_LAST)
    |=> (track_en && cyc_reg == aqc_pkg::CYC_FIRST))
    else $error("no track after sixteenth cycle");
  chk_zero_fill: assert property (
    (cyc_reg < aqc_pkg::CYC_MSB || cyc_reg > aqc_pkg::CYC_LSB) |-> !dout)
    else $error("data out not zero outside result bits");

  cov_back_to_back: cover property (
    (ce && sclk_fall && cyc_reg == aqc_pkg::CYC_LAST && !cs_high));
  cov_chan_four: cover property (
    (ce && start_conv && chan_reg == 2'h3));
  cov_buf_full: cover property (
    (res_valid && !res_ready && !buf_in_ready));
  cov_result_lost: cover property (res_lost);
  cov_start_clk_high: cover property (
    (ce && start_conv && sclk_fall && cyc_reg == aqc_pkg::CYC_NONE));
endmodule

// File: verif/aqc_host_model.sv
// Purpose: Host serial controller that frames conversions for the converter block.
// Assumes: Runs from core_clk; one serial period is eight core cycles.
// Notes:   Serial clock stands low between frames; unused data-in bits toggle.
module aqc_host_model (
  // Clock
  input  wire logic       core_clk,
  // Device answers and probes
  input  wire logic       dout,
  input  wire logic       dout_oe_n,
  input  wire logic       track_en,
  input  wire logic       hold_en,
  input  wire logic [1:0] mux_sel,
  // Serial pins toward the device
  output logic            cs_n_pin,
  output logic            sclk_pin,
  output logic            din_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  ctrl_word [4];
  logic [63:0] cap_dout;
  logic [63:0] cap_oe_n;
  logic [63:0] cap_trk;
  logic [63:0] cap_hld;
  logic [1:0]  cap_sel [64];

  // Idle pins at time zero
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    din_pin  = 1'b0;
  end

  // Frame of nconv conversions; stop_rise above zero cuts it after that rise
  // With sclk_hi the clock is parked high across the select fall
  task automatic frame(input int nconv, input int stop_rise, input bit sclk_hi);
    int         r;
    logic [7:0] w;
    if (sclk_hi) begin
      @(posedge core_clk);
      sclk_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      cs_n_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    for (r = 0; r < nconv * 16; r++) begin
      w = ctrl_word[r / 16];
      @(posedge core_clk);
      if (r == 0 && !sclk_hi)
        cs_n_pin <= 1'b0;
      else
        sclk_pin <= 1'b0;
      din_pin <= (r % 16 < 8) ? w[7 - r % 16] : ~din_pin;
      repeat (3) @(posedge core_clk);
      // Sample just before the rise, where the answer has settled
      @(negedge core_clk);
      cap_dout[r] = dout;
      cap_oe_n[r] = dout_oe_n;
      cap_trk[r]  = track_en;
      cap_hld[r]  = hold_en;
      cap_sel[r]  = mux_sel;
      @(posedge core_clk);
      sclk_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      if (r + 1 == stop_rise)
        break;
    end
    // Close on a low clock so the next frame starts from a known level
    @(posedge core_clk);
    sclk_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    cs_n_pin <= 1'b1;
    din_pin  <= ~din_pin;
  endtask
endmodule

// File: verif/test_quad_channel_adc_serial_control.sv
// Purpose: Self-checking bench for the converter serial control block.
// Assumes: Host model drives the serial pins; core clock 25 ns, serial 200 ns.
// Notes:   The result buffer is stalled through one frame to force drops.
module test_quad_channel_adc_serial_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 core_clk  = 1'b0;
  logic                 rst       = 1'b1;
  logic                 res_ready = 1'b0;
  logic                 cs_n_pin, sclk_pin, din_pin, dout, dout_oe_n;
  logic                 track_en, hold_en, res_valid, res_lost;
  logic [1:0]           mux_sel;
  aqc_pkg::aqc_result_t res_data;
  logic [7:0]           lvl [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
  int                   error_cnt = 0;
  int                   compares  = 0;
  int                   lost_cnt  = 0;

  always #12.5 core_clk = ~core_clk;

  // Count dropped results; only two fit in the buffer
  always @(negedge core_clk) if (res_lost === 1'b1) lost_cnt++;

  aqc_serial_ctrl u_dut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .din_pin(din_pin), .dout(dout), .dout_oe_n(dout_oe_n),
    .analog_input_one(lvl[0]), .analog_input_two(lvl[1]), .analog_input_three(lvl[2]),
    .analog_input_four(lvl[3]), .mux_sel(mux_sel), .track_en(track_en), .hold_en(hold_en),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data), .res_lost(res_lost));

  aqc_host_model u_host (.core_clk(core_clk), .dout(dout), .dout_oe_n(dout_oe_n),
    .track_en(track_en), .hold_en(hold_en), .mux_sel(mux_sel), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .din_pin(din_pin));

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic cmp_vec(input string name, input logic [9:0] exp, input logic [9:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Judge one captured conversion against its channel and input level
  task automatic check_conv(input int base, input logic [1:0] chan);
    int   k;
    logic e;
    for (k = 0; k < 16; k++) begin
      e = (k >= 4 && k <= 11) ? lvl[chan][11 - k] : 1'b0;
      cmp_bit("dout", e, u_host.cap_dout[base + k]);
      cmp_bit("oe_n", 1'b0, u_host.cap_oe_n[base + k]);
      cmp_bit("track", k < 3, u_host.cap_trk[base + k]);
      cmp_bit("hold", k >= 3, u_host.cap_hld[base + k]);
      cmp_vec("mux_sel", {8'h00, chan}, {8'h00, u_host.cap_sel[base + k]});
    end
  endtask

  // Wait for a result under a bound, check it, then pop it
  task automatic pop_expect(input logic [9:0] exp);
    int n;
    @(negedge core_clk);
    for (n = 0; n < 50 && res_valid !== 1'b1; n++) @(negedge core_clk);
    if (n == 50) begin
      cmp_bit("res_valid", 1'b1, res_valid);
      results();
    end
    cmp_vec("res_data", exp, res_data);
    @(posedge core_clk);
    res_ready <= 1'b1;
    @(posedge core_clk);
    res_ready <= 1'b0;
  endtask

  task automatic idle_check();
    repeat (4) @(negedge core_clk);
    cmp_bit("oe_n", 1'b1, dout_oe_n);
    cmp_bit("dout", 1'b0, dout);
  endtask

  task automatic sc_reset();
    cmp_bit("oe_n", 1'b1, dout_oe_n);
    cmp_bit("track", 1'b0, track_en);
    cmp_vec("mux_sel", 10'h000, {8'h00, mux_sel});
    cmp_bit("res_valid", 1'b0, res_valid);
  endtask

  // First conversion after reset; word picks input one with all ignored bits set
  task automatic sc_first();
    u_host.ctrl_word[0] = 8'hE7;
    u_host.frame(1, 0, 1'b0);
    check_conv(0, 2'h0);
    idle_check();
    pop_expect({2'h0, lvl[0]});
  endtask

  // Four conversions in one frame while the reader stalls
  task automatic sc_stall();
    u_host.ctrl_word = '{8'h08, 8'h37, 8'hDF, 8'h27};
    lost_cnt = 0;
    u_host.frame(4, 0, 1'b0);
    for (int c = 0; c < 4; c++) check_conv(c * 16, 2'(c));
    cmp_vec("lost", 10'h002, 10'(lost_cnt));
    pop_expect({2'h0, lvl[0]});
    pop_expect({2'h1, lvl[1]});
    @(negedge core_clk);
    cmp_bit("res_valid", 1'b0, res_valid);
  endtask

  // Frame cut after the third rise, before the address completes;
  // the retry starts with the serial clock parked high
  task automatic sc_abort();
    u_host.ctrl_word[0] = 8'h18;
    u_host.frame(1, 3, 1'b0);
    idle_check();
    cmp_bit("track", 1'b0, track_en);
    cmp_bit("res_valid", 1'b0, res_valid);
    u_host.ctrl_word[0] = 8'h00;
    u_host.frame(1, 0, 1'b1);
    check_conv(0, 2'h0);
    pop_expect({2'h0, lvl[0]});
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(negedge core_clk);
    sc_reset();
    sc_first();
    sc_stall();
    sc_abort();
    results();
  end
endmodule
